/* File: design/rcl_device.sv */
// Transceiver end: serial shift register, parallel register and amplifier sequencing.
`timescale 1ns/100ps
`default_nettype none
module rcl_device
  import rcl_pkg::*;
#(
  parameter int RAMP_CYC = RAMP_STEP_CYC
) (
  // Clock and reset.
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // Link to the host.
  rcl_link_if.dev                   link,
  // Radio side.
  input  wire logic                 rx_data_in,
  input  wire logic                 pll_locked_in,
  output logic      [A_BITS-1:0]    active_swallow_div,
  output logic      [N_BITS-1:0]    active_main_div,
  output logic      [M_BITS-1:0]    active_ref_div,
  output logic      [CTRL_BITS-1:0] control_word,
  output logic                      div_set_sel,
  output logic                      amp_enable_internal,
  output logic      [2:0]           pa_ramp_level,
  output logic                      powered_up,
  output logic                      tx_mode,
  output logic                      load_pulse
);

  localparam int NIN = 5;
  localparam int I_SCK = 0;
  localparam int I_STB = 1;
  localparam int I_DAT = 2;
  localparam int I_PD  = 3;
  localparam int I_PIN = 4;

  typedef enum logic [2:0] {
    RCL_IDLE = 3'h0,
    RCL_ARM  = 3'h1,
    RCL_UP   = 3'h3,
    RCL_ON   = 3'h2,
    RCL_DN   = 3'h6
  } rcl_pa_state_type;

  typedef struct packed {
    logic [NIN-1:0][2:0]    sync;
    logic [NIN-1:0]         filt;
    logic [WORD_BITS-1:0]   shift;
    logic [WORD_BITS-1:0]   par;
    rcl_pa_state_type       st;
    logic [2:0]             ramp;
    logic [15:0]            tick;
    logic [A_BITS-1:0]      a_out;
    logic [N_BITS-1:0]      n_out;
    logic [M_BITS-1:0]      m_out;
    logic                   sel;
    logic                   amp;
    logic                   pwr;
    logic                   tx;
    logic                   load;
    logic                   lock;
    logic                   d_out;
    logic                   d_oe;
  } rcl_dev_state_type;

  rcl_dev_state_type state_ff;
  rcl_dev_state_type nxt_state;
  logic [NIN-1:0]    pins;

  assign pins = {link.tx_rx_data_pin, link.ext_powerdown_pin, link.serial_data,
                 link.load_strobe_in, link.serial_shift_clock};

  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic strobe_evt;
    logic ramp_step;
    logic do_load;
    logic [2:0] target;
    logic [1:0] mode;
    sck_rise   = 1'b0;
    sck_fall   = 1'b0;
    strobe_evt = 1'b0;
    ramp_step  = 1'b0;
    do_load    = 1'b0;
    target     = 3'h0;
    mode       = 2'h0;
    nxt_state  = state_ff;
    nxt_state.load = 1'b0;
    // A pin change counts once the second and third stages agree.
    for (int i = 0; i < NIN; i++) begin
      nxt_state.sync[i] = {state_ff.sync[i][1:0], pins[i]};
      if (state_ff.sync[i][1] == state_ff.sync[i][2]) begin
        nxt_state.filt[i] = state_ff.sync[i][2];
      end
    end
    sck_rise = nxt_state.filt[I_SCK] & ~state_ff.filt[I_SCK];
    sck_fall = ~nxt_state.filt[I_SCK] & state_ff.filt[I_SCK];
    strobe_evt = (nxt_state.filt[I_STB] != state_ff.filt[I_STB]) & state_ff.filt[I_SCK];
    if (sck_rise) begin
      nxt_state.shift = {state_ff.shift[WORD_BITS-2:0], nxt_state.filt[I_DAT]};
    end
    target = state_ff.par[PA_LSB +: 3];
    if (state_ff.tick != 16'h0) begin
      nxt_state.tick = state_ff.tick - 16'h1;
    end else if (state_ff.st == RCL_UP || state_ff.st == RCL_DN) begin
      ramp_step = 1'b1;
      nxt_state.tick = 16'(RAMP_CYC - 1);
    end
    case (state_ff.st)
      RCL_IDLE: begin
        if (strobe_evt) begin
          do_load = 1'b1;
        end
      end
      RCL_ARM: begin
        if (strobe_evt) begin
          do_load = 1'b1;
        end else if (sck_fall) begin
          nxt_state.st   = RCL_UP;
          nxt_state.tick = 16'(RAMP_CYC - 1);
        end
      end
      RCL_UP: begin
        if (strobe_evt) begin
          nxt_state.st = RCL_DN;
        end else if (state_ff.ramp >= target) begin
          nxt_state.st = RCL_ON;
        end else if (ramp_step) begin
          nxt_state.ramp = state_ff.ramp + 3'h1;
        end
      end
      RCL_ON: begin
        if (strobe_evt) begin
          nxt_state.st   = RCL_DN;
          nxt_state.tick = 16'(RAMP_CYC - 1);
        end
      end
      RCL_DN: begin
        if (state_ff.ramp == 3'h0) begin
          do_load = 1'b1;
        end else if (ramp_step) begin
          nxt_state.ramp = state_ff.ramp - 3'h1;
        end
      end
      default: begin
        nxt_state.st = RCL_IDLE;
      end
    endcase
    if (do_load) begin
      nxt_state.par  = state_ff.shift;
      nxt_state.load = 1'b1;
      nxt_state.ramp = 3'h0;
      nxt_state.st   = state_ff.shift[RT_BIT] ? RCL_ARM : RCL_IDLE;
    end
    nxt_state.pwr = state_ff.par[PU_BIT] & state_ff.filt[I_PD];
    nxt_state.tx  = state_ff.par[RT_BIT];
    // The amplifier is gated by the powered-up flag of the cycle before, so it stops one cycle after power down.
    nxt_state.amp = state_ff.pwr & state_ff.tx &
                    (state_ff.st == RCL_UP || state_ff.st == RCL_ON ||
                     (state_ff.st == RCL_DN && state_ff.ramp != 3'h0));
    mode = state_ff.par[MOD_LSB +: 2];
    // switching picks set; oscillator uses set 1
    nxt_state.sel = (mode == MOD_SWITCH) ? state_ff.filt[I_PIN] : 1'b1;
    nxt_state.a_out = state_ff.sel ? state_ff.par[A1_LSB +: A_BITS] : state_ff.par[A0_LSB +: A_BITS];
    nxt_state.n_out = state_ff.sel ? state_ff.par[N1_LSB +: N_BITS] : state_ff.par[N0_LSB +: N_BITS];
    nxt_state.m_out = state_ff.sel ? state_ff.par[M1_LSB +: M_BITS] : state_ff.par[M0_LSB +: M_BITS];
    nxt_state.lock  = pll_locked_in;
    // Receive data goes out on the shared pin when powered up in receive; otherwise the device releases it to the host.
    nxt_state.d_oe  = state_ff.pwr & ~state_ff.tx;
    nxt_state.d_out = rx_data_in;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign link.pll_lock_flag  = state_ff.lock;
  assign link.dev_data_out   = state_ff.d_out;
  assign link.dev_data_oe    = state_ff.d_oe;
  assign active_swallow_div  = state_ff.a_out;
  assign active_main_div     = state_ff.n_out;
  assign active_ref_div      = state_ff.m_out;
  assign control_word        = state_ff.par[CTRL_BITS-1:0];
  assign div_set_sel         = state_ff.sel;
  assign amp_enable_internal = state_ff.amp;
  assign pa_ramp_level       = state_ff.ramp;
  assign powered_up          = state_ff.pwr;
  assign tx_mode             = state_ff.tx;
  assign load_pulse          = state_ff.load;

endmodule : rcl_device
`default_nettype wire

/* File: design/rcl_host.sv */
// Host end: AHB-Lite register slave that shifts and loads the control word.
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module rcl_host
  import rcl_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC,
  parameter int HOLD_CYC = LOAD_HOLD_CYC
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt.
  output logic             irq,
  // Link to the device.
  rcl_link_if.host         link
);

  typedef enum logic [2:0] {
    RCL_H_IDLE = 3'h0,
    RCL_H_LOW  = 3'h1,
    RCL_H_HIGH = 3'h3,
    RCL_H_STB  = 3'h2,
    RCL_H_HOLD = 3'h6,
    RCL_H_LOCK = 3'h7
  } rcl_host_state_type;

  typedef struct packed {
    logic                 wr_pend;
    logic [7:0]           addr;
    logic [31:0]          rdata;
    logic [3:0]           ctrl;
    logic [WORD_BITS-1:0] word;
    logic [WORD_BITS-1:0] sreg;
    logic [IRQ_BITS-1:0]  ist;
    logic [IRQ_BITS-1:0]  ien;
    logic                 irq;
    rcl_host_state_type   st;
    logic [6:0]           bits;
    logic [15:0]          cnt;
    logic                 sck;
    logic                 sdat;
    logic                 stb;
    logic                 first_done;
    logic                 pd;
    logic [2:0]           lsync;
    logic                 lock;
    logic [2:0]           dsync;
    logic                 dpin;
  } rcl_host_regs_type;

  rcl_host_regs_type state_ff;
  rcl_host_regs_type nxt_state;

  always_comb begin
    logic start;
    logic tick;
    logic lock_rise;
    logic [IRQ_BITS-1:0] ev;
    logic [IRQ_BITS-1:0] clr;
    start     = 1'b0;
    tick      = 1'b0;
    lock_rise = 1'b0;
    ev        = '0;
    clr       = '0;
    nxt_state = state_ff;
    nxt_state.lsync = {state_ff.lsync[1:0], link.pll_lock_flag};
    nxt_state.dsync = {state_ff.dsync[1:0], link.tx_rx_data_pin};
    if (state_ff.lsync[1] == state_ff.lsync[2]) begin
      nxt_state.lock = state_ff.lsync[2];
    end
    if (state_ff.dsync[1] == state_ff.dsync[2]) begin
      nxt_state.dpin = state_ff.dsync[2];
    end
    lock_rise = nxt_state.lock & ~state_ff.lock;
    // Data phase of a write.
    if (state_ff.wr_pend) begin
      case (state_ff.addr)
        OFS_CTRL:    nxt_state.ctrl = hwdata[3:0];
        OFS_CMD:     start = hwdata[0];
        OFS_WORD0:   nxt_state.word[31:0] = hwdata;
        OFS_WORD1:   nxt_state.word[63:32] = hwdata;
        OFS_WORD2:   nxt_state.word[79:64] = hwdata[15:0];
        OFS_IRQ_CLR: clr = hwdata[IRQ_BITS-1:0];
        OFS_IRQ_EN:  nxt_state.ien = hwdata[IRQ_BITS-1:0];
        default: begin
        end
      endcase
    end
    tick = (state_ff.cnt == 16'h0);
    if (!tick) begin
      nxt_state.cnt = state_ff.cnt - 16'h1;
    end
    case (state_ff.st)
      RCL_H_IDLE: begin
        // A start while busy is ignored.
        if (start) begin
          nxt_state.sreg = nxt_state.word;
          nxt_state.sdat = nxt_state.word[WORD_BITS-1];
          nxt_state.bits = 7'(WORD_BITS);
          nxt_state.sck  = 1'b0;
          nxt_state.cnt  = 16'(HALF_CYC - 1);
          nxt_state.st   = RCL_H_LOW;
        end
      end
      RCL_H_LOW: begin
        if (tick) begin
          nxt_state.sck = 1'b1;
          nxt_state.cnt = 16'(HALF_CYC - 1);
          nxt_state.st  = RCL_H_HIGH;
        end
      end
      RCL_H_HIGH: begin
        if (tick && state_ff.bits == 7'h1) begin
          nxt_state.cnt = 16'(HALF_CYC - 1);
          nxt_state.st  = RCL_H_STB;
        end else if (tick) begin
          nxt_state.sreg = {state_ff.sreg[WORD_BITS-2:0], 1'b0};
          nxt_state.sdat = state_ff.sreg[WORD_BITS-2];
          nxt_state.bits = state_ff.bits - 7'h1;
          nxt_state.sck  = 1'b0;
          nxt_state.cnt  = 16'(HALF_CYC - 1);
          nxt_state.st   = RCL_H_LOW;
        end
      end
      RCL_H_STB: begin
        if (tick) begin
          nxt_state.stb = ~state_ff.stb;
          nxt_state.cnt = 16'(HOLD_CYC - 1);
          nxt_state.st  = RCL_H_HOLD;
        end
      end
      RCL_H_HOLD: begin
        if (tick) begin
          nxt_state.first_done = 1'b1;
          nxt_state.st         = RCL_H_LOCK;
        end
      end
      RCL_H_LOCK: begin
        if (!state_ff.ctrl[CTRL_WLOCK_BIT] || state_ff.lock) begin
          nxt_state.sck = 1'b0;
          ev[IRQ_DONE_BIT] = 1'b1;
          nxt_state.st = RCL_H_IDLE;
        end
      end
      default: begin
        nxt_state.st = RCL_H_IDLE;
      end
    endcase
    nxt_state.pd = state_ff.ctrl[CTRL_RUN_BIT] & state_ff.first_done;
    ev[IRQ_LOCK_BIT] = lock_rise;
    // A new event wins over a clear in the same cycle.
    nxt_state.ist = (state_ff.ist & ~clr) | ev;
    nxt_state.irq = |(nxt_state.ist & nxt_state.ien);
    // Address phase; read data reflect any write landing this cycle.
    nxt_state.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      nxt_state.wr_pend = hwrite;
      nxt_state.addr    = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
      case ((haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF)
        OFS_CTRL:   nxt_state.rdata = {28'h0, nxt_state.ctrl};
        OFS_WORD0:  nxt_state.rdata = nxt_state.word[31:0];
        OFS_WORD1:  nxt_state.rdata = nxt_state.word[63:32];
        OFS_WORD2:  nxt_state.rdata = {16'h0, nxt_state.word[79:64]};
        OFS_STATUS: nxt_state.rdata = {29'h0, state_ff.dpin, state_ff.lock,
                                       state_ff.st != RCL_H_IDLE};
        OFS_IRQ_ST: nxt_state.rdata = {30'h0, nxt_state.ist};
        OFS_IRQ_EN: nxt_state.rdata = {30'h0, nxt_state.ien};
        default:    nxt_state.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign hrdata                 = state_ff.rdata;
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign irq                    = state_ff.irq;
  assign link.serial_shift_clock = state_ff.sck;
  assign link.serial_data        = state_ff.sdat;
  assign link.load_strobe_in     = state_ff.stb;
  assign link.ext_powerdown_pin  = state_ff.pd;
  assign link.host_data_out      = state_ff.ctrl[CTRL_DVAL_BIT];
  assign link.host_data_oe       = state_ff.ctrl[CTRL_DOE_BIT];

endmodule : rcl_host
`default_nettype wire

/* File: design/rcl_link_if.sv */
// Serial programming link between host controller and transceiver.
`timescale 1ns/100ps
`default_nettype none
interface rcl_link_if;
  logic serial_shift_clock;
  logic serial_data;
  logic load_strobe_in;
  logic ext_powerdown_pin;
  logic pll_lock_flag;
  logic dev_data_out;
  logic dev_data_oe;
  logic host_data_out;
  logic host_data_oe;
  logic tx_rx_data_pin;
  // Wire level resolved from the enables; an undriven pin reads low.
  assign tx_rx_data_pin = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 1'b0);
  modport dev (input serial_shift_clock, serial_data, load_strobe_in, ext_powerdown_pin,
               input tx_rx_data_pin, output pll_lock_flag, dev_data_out, dev_data_oe);
  modport host (output serial_shift_clock, serial_data, load_strobe_in, ext_powerdown_pin,
                output host_data_out, host_data_oe, input pll_lock_flag, tx_rx_data_pin);
endinterface : rcl_link_if
`default_nettype wire

/* File: design/rcl_pkg.sv */
// Shared constants for the control word loader and its host controller.
package rcl_pkg;
  // Control word layout, most significant bit shifted first.
  localparam int WORD_BITS    = 80;
  localparam int A1_LSB       = 74;
  localparam int A0_LSB       = 68;
  localparam int A_BITS       = 6;
  localparam int N1_LSB       = 56;
  localparam int N0_LSB       = 44;
  localparam int N_BITS       = 12;
  localparam int M1_LSB       = 34;
  localparam int M0_LSB       = 24;
  localparam int M_BITS       = 10;
  localparam int CTRL_BITS    = 24;
  localparam int PU_BIT       = 0;
  localparam int RT_BIT       = 1;
  localparam int MOD_LSB      = 2;
  localparam int PA_LSB       = 20;
  localparam logic [1:0] MOD_VCO    = 2'h0;
  localparam logic [1:0] MOD_SWITCH = 2'h2;
  // Timing.
  localparam int CLK_MHZ       = 100;
  localparam int SCK_HALF_NS   = 80;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS * CLK_MHZ) / 1000;
  localparam int RAMP_STEP_NS  = 200;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_MHZ) / 1000;
  localparam int LOAD_HOLD_NS  = 10000;
  localparam int LOAD_HOLD_CYC = (LOAD_HOLD_NS * CLK_MHZ + 999) / 1000;
  // Host register byte offsets.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_WORD0   = 8'h08;
  localparam logic [7:0] OFS_WORD1   = 8'h0C;
  localparam logic [7:0] OFS_WORD2   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h20;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_WLOCK_BIT = 1;
  localparam int CTRL_DOE_BIT   = 2;
  localparam int CTRL_DVAL_BIT  = 3;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_LOCK_BIT   = 1;
  localparam int IRQ_BITS       = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
endpackage : rcl_pkg

/* File: verification/rcl_link_sva.sv */
// Concurrent checks on the serial programming link between host and transceiver ends.
`timescale 1ns/100ps
`default_nettype none
module rcl_link_sva
#(
  parameter int HOLD_CYC = 1000
) (
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Link signals.
  input  wire logic serial_shift_clock,
  input  wire logic serial_data,
  input  wire logic load_strobe_in,
  input  wire logic ext_powerdown_pin
);
  logic        sck_ff;
  logic        strobe_ff;
  logic        in_hold_ff;
  logic        first_done_ff;
  logic [6:0]  rise_cnt_ff;
  logic [10:0] hold_cnt_ff;
  wire logic   strobe_chg = load_strobe_in != strobe_ff;

  // Rises are counted between strobe toggles; the hold phase runs from a toggle to the next fall.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_ff        <= 1'b0;
      strobe_ff     <= 1'b0;
      in_hold_ff    <= 1'b0;
      first_done_ff <= 1'b0;
      rise_cnt_ff   <= 7'h00;
      hold_cnt_ff   <= 11'h000;
    end else begin
      sck_ff    <= serial_shift_clock;
      strobe_ff <= load_strobe_in;
      if (strobe_chg) begin
        rise_cnt_ff <= 7'h00;
      end else if (serial_shift_clock && !sck_ff) begin
        rise_cnt_ff <= rise_cnt_ff + 7'h01;
      end
      if (strobe_chg) begin
        in_hold_ff  <= 1'b1;
        hold_cnt_ff <= 11'h000;
      end else if (in_hold_ff && !serial_shift_clock) begin
        in_hold_ff    <= 1'b0;
        first_done_ff <= 1'b1;
      end else if (in_hold_ff) begin
        hold_cnt_ff <= hold_cnt_ff + 11'h001;
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_high;
    serial_shift_clock [*7];
  endsequence
  sequence s_low;
    !serial_shift_clock [*7];
  endsequence

  strobe_clock_high_a : assert property (strobe_chg |-> serial_shift_clock)
    else $error("strobe toggled while the shift clock was low");
  word_length_a : assert property (strobe_chg |-> rise_cnt_ff == 7'h50)
    else $error("load strobe not preceded by exactly 80 shift clock rises");
  data_steady_a : assert property ($changed(serial_data) |-> !serial_shift_clock)
    else $error("serial data changed while the shift clock was high");
  high_half_a : assert property ($rose(serial_shift_clock) |=> s_high)
    else $error("shift clock high phase too short");
  low_half_a : assert property ($fell(serial_shift_clock) |=> s_low)
    else $error("shift clock low phase too short");
  hold_time_a : assert property (in_hold_ff && !serial_shift_clock |-> hold_cnt_ff >= HOLD_CYC - 2)
    else $error("shift clock fell too soon after the load strobe");
  load_hold_high_a : assert property (strobe_chg |-> ##1 serial_shift_clock [*8])
    else $error("shift clock dropped right after the load strobe");
  load_release_a : assert property (strobe_chg |-> ##[1:1000] !serial_shift_clock)
    else $error("shift clock never returned low after a load");
  first_pd_low_a : assert property (!first_done_ff && !(in_hold_ff && !serial_shift_clock)
                                    |-> !ext_powerdown_pin)
    else $error("power-down pin released before the first load finished");
  load_seen_c : cover property (strobe_chg && in_hold_ff == 1'b0);
endmodule : rcl_link_sva
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench: AHB-Lite host end programming the transceiver end over the link.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rcl_pkg::*;
  localparam int HOLD = 200;
  localparam int RAMP = 20;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pa_lvl;
  logic [2:0]  lvl_at_load = 3'h0;
  logic        rx_data_in, pll_locked_in, set_sel, amp_on, pwr_up, tx_on, load_pulse;
  logic [5:0]  act_a;
  logic [11:0] act_n;
  logic [9:0]  act_m;
  logic [23:0] ctrl_out;
  logic        strb_prev = 1'b0;
  int          err_total, checked, n;
  int          load_cnt = 0, cyc = 0, strb_t = 0, load_t = 0;
  rcl_link_if link ();
  rcl_host #(.HALF_CYC(8), .HOLD_CYC(HOLD)) u_rcl_host (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .link(link));
  rcl_device #(.RAMP_CYC(RAMP)) u_rcl_device (.hclk(hclk), .hresetn(hresetn), .link(link),
    .rx_data_in(rx_data_in), .pll_locked_in(pll_locked_in), .active_swallow_div(act_a),
    .active_main_div(act_n), .active_ref_div(act_m), .control_word(ctrl_out),
    .div_set_sel(set_sel), .amp_enable_internal(amp_on), .pa_ramp_level(pa_lvl),
    .powered_up(pwr_up), .tx_mode(tx_on), .load_pulse(load_pulse));
  rcl_link_sva #(.HOLD_CYC(HOLD)) u_rcl_link_sva (.hclk(hclk), .hresetn(hresetn),
    .serial_shift_clock(link.serial_shift_clock), .serial_data(link.serial_data),
    .load_strobe_in(link.load_strobe_in), .ext_powerdown_pin(link.ext_powerdown_pin));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Records when the strobe toggles and what the amplifier level is at each parallel load.
  always @(posedge hclk) begin
    cyc       <= cyc + 1;
    strb_prev <= link.load_strobe_in;
    if (link.load_strobe_in !== strb_prev) strb_t <= cyc;
    if (load_pulse === 1'b1) begin
      load_cnt    <= load_cnt + 1;
      load_t      <= cyc;
      lvl_at_load <= pa_lvl;
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // One single-word transfer; called right after a rising edge.
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    ahb(a, 1'b0, 32'h00000000);
    chk(nm, exp, rd);
  endtask : rd_chk

  function automatic logic [23:0] mkc(input logic [2:0] pa, input logic [1:0] md,
                                      input logic rt, input logic pu);
    logic [23:0] c;
    c = 24'h800000;
    c[PA_LSB+:3]  = pa;
    c[MOD_LSB+:2] = md;
    c[RT_BIT]     = rt;
    c[PU_BIT]     = pu;
    return c;
  endfunction : mkc

  task automatic start(input logic [23:0] c, input logic one_set);
    logic [79:0] w;
    w = {6'h09, 6'h1B, 12'h089, 12'h086, 10'h065, 10'h063, c};
    // one divider set in both slots
    if (one_set) w[79:24] = {6'h09, 6'h09, 12'h089, 12'h089, 10'h065, 10'h065};
    wr(OFS_WORD0, w[31:0]);
    wr(OFS_WORD1, w[63:32]);
    wr(OFS_WORD2, {16'h0000, w[79:64]});
    wr(OFS_CMD, 32'h00000001);
  endtask : start

  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      ahb(OFS_STATUS, 1'b0, 32'h00000000);
      if (rd[0] === 1'b0) break;
    end
    chk("busy", 32'h0, {31'h0, rd[0]});
  endtask : wait_idle

  task automatic wait_load(input int k);
    for (int i = 0; i < 3000 && load_cnt < k; i++) @(posedge hclk);
    chk("load_count", k, load_cnt);
  endtask : wait_load

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, rx_data_in, pll_locked_in} = '0;
    {err_total, checked, n} = '0;
    hsize       = 3'h2;
    hresetn     = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(OFS_CTRL, 32'h0, "ctrl_reset");
    chk("hresp_okay", 32'h0, hresp);
    rd_chk(OFS_IRQ_ST, 32'h0, "irq_st_reset");
    chk("sck_idle", 32'h0, link.serial_shift_clock);
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h0, "unmapped");
    // Receive word with divider switching; power-up pin allowed only after this first load.
    wr(OFS_CTRL, 32'h1);
    wr(OFS_IRQ_EN, 32'h1);
    start(mkc(3'h7, MOD_SWITCH, 1'b0, 1'b1), 1'b0);
    repeat (300) @(posedge hclk);
    chk("pd_first", 32'h0, link.ext_powerdown_pin);
    wait_idle();
    repeat (4) @(posedge hclk);
    chk("irq_done", 32'h1, irq);
    chk("ctrl_word", mkc(3'h7, MOD_SWITCH, 1'b0, 1'b1), ctrl_out);
    chk("pd_pin", 32'h1, link.ext_powerdown_pin);
    chk("powered", 32'h1, pwr_up);
    rx_data_in <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("set0_a", 32'h1B, act_a);
    chk("set0_n", 32'h086, act_n);
    chk("set0_m", 32'h063, act_m);
    rx_data_in <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("set1_a", 32'h09, act_a);
    chk("set1_n", 32'h089, act_n);
    chk("set1_m", 32'h065, act_m);
    wr(OFS_IRQ_CLR, 32'h1);
    repeat (3) @(posedge hclk);
    chk("irq_clr", 32'h0, irq);
    // Transmit word with oscillator modulation; a second start while busy is ignored.
    wr(OFS_CTRL, 32'h5);
    n = load_cnt;
    start(mkc(3'h5, MOD_VCO, 1'b1, 1'b1), 1'b0);
    wr(OFS_CMD, 32'h00000001);
    repeat (300) @(posedge hclk);
    chk("cfg_kept", mkc(3'h7, MOD_SWITCH, 1'b0, 1'b1), ctrl_out);
    wait_load(n + 1);
    repeat (10) @(posedge hclk);
    chk("amp_before_fall", 32'h0, amp_on);
    chk("tx_mode", 32'h1, tx_on);
    wait_idle();
    repeat (6 * RAMP + 10) @(posedge hclk);
    chk("ramp_top", 32'h5, pa_lvl);
    chk("amp_on", 32'h1, amp_on);
    chk("vco_sel", 32'h1, set_sel);
    chk("vco_a", 32'h09, act_a);
    chk("one_load", n + 1, load_cnt);
    // The host now drives the shared data pin high.
    wr(OFS_CTRL, 32'hD);
    repeat (6) @(posedge hclk);
    rd_chk(OFS_STATUS, 32'h4, "status_pin");
    // Reload into power down while the amplifier is fully on.
    n = load_cnt;
    start(mkc(3'h5, MOD_SWITCH, 1'b0, 1'b0), 1'b0);
    wait_idle();
    chk("reload", n + 1, load_cnt);
    chk("lvl_at_load", 32'h0, lvl_at_load);
    chk("ramp_down_time", 32'h1, {31'h0, (load_t - strb_t) >= 5 * RAMP});
    chk("powered_off", 32'h0, pwr_up);
    chk("amp_off", 32'h0, amp_on);
    // Lock wait holds the clock high; the done interrupt is masked, then the lock one enabled.
    wr(OFS_IRQ_CLR, 32'h3);
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_CTRL, 32'h3);
    n = load_cnt;
    start(mkc(3'h2, MOD_VCO, 1'b1, 1'b1), 1'b1);
    wait_load(n + 1);
    repeat (400) @(posedge hclk);
    chk("sck_wait_lock", 32'h1, link.serial_shift_clock);
    pll_locked_in <= 1'b1;
    wait_idle();
    rd_chk(OFS_IRQ_ST, 32'h3, "irq_st_both");
    rd_chk(OFS_STATUS, 32'h2, "status_lock");
    chk("one_set_a", 32'h09, act_a);
    chk("irq_masked", 32'h0, irq);
    wr(OFS_IRQ_EN, 32'h2);
    repeat (3) @(posedge hclk);
    chk("irq_lock", 32'h1, irq);
    wr(OFS_IRQ_CLR, 32'h2);
    repeat (3) @(posedge hclk);
    chk("irq_lock_clr", 32'h0, irq);
    rd_chk(OFS_IRQ_ST, 32'h1, "irq_st_left");
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge hclk);
    err_total++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
